/* verilog/nvc_top.sv */
// i2c slave holding the 5-bit nonvolatile ratio configuration word
`include "nvc_cfg.svh"
module nvc_top (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       mux_select,
  input  wire logic       override,
  input  wire logic [3:0] pass_in,
  output logic [3:0]      core_ratio_code,
  output logic            latched_aux_output
);
  // **************************************
  // pin conditioning and bus events
  // **************************************
  logic scl_s;
  logic sda_s;
  logic scl_d_r;
  logic sda_d_r;
  nvc_sync u_scl (.sys_clk(sys_clk), .reset(reset), .raw_in(scl_in), .clean_r(scl_s));
  nvc_sync u_sda (.sys_clk(sys_clk), .reset(reset), .raw_in(sda_in), .clean_r(sda_s));
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end
  // 50 oversampling clocks per 400 kHz bit leaves ample margin
  wire scl_rise  = scl_s & ~scl_d_r;
  wire scl_fall  = ~scl_s & scl_d_r;
  wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  // **************************************
  // storage
  // **************************************
  // flops stand in for the eeprom cells; the reset value models an erased part.
  // true retention across power loss needs a real nonvolatile macro.
  logic [`NVC_WORD_BITS-1:0] word_r;
  logic [`NVC_WORD_BITS-1:0] word_nxt;
  nvc_pkg::nvc_state_e       state_r;
  nvc_pkg::nvc_state_e       state_nxt;
  logic [7:0]                shift_r;
  logic [7:0]                shift_nxt;
  logic [3:0]                cnt_r;
  logic [3:0]                cnt_nxt;
  logic                      rd_r;
  logic                      rd_nxt;
  logic                      sda_out_nxt;
  logic                      sda_oe_nxt;
  wire [7:0] rd_byte    = {3'h0, word_r};
  wire [7:0] shift_in   = {shift_r[6:0], sda_s};
  wire       addr_match = (shift_in[7:1] == `NVC_SLAVE_ADDR);
  wire       byte_done  = (cnt_r == 4'h7);
  // **************************************
  // protocol engine
  // **************************************
  always_comb begin
    state_nxt   = state_r;
    shift_nxt   = shift_r;
    cnt_nxt     = cnt_r;
    rd_nxt      = rd_r;
    word_nxt    = word_r;
    sda_out_nxt = sda_out;
    sda_oe_nxt  = sda_oe;
    if (start_det) begin
      state_nxt  = nvc_pkg::ST_ADDR;
      cnt_nxt    = 4'h0;
      sda_oe_nxt = 1'b0;
    end else if (stop_det) begin
      state_nxt  = nvc_pkg::ST_IDLE;
      sda_oe_nxt = 1'b0;
    end else begin
      unique case (state_r)
        nvc_pkg::ST_IDLE: begin
          sda_oe_nxt = 1'b0;
        end
        nvc_pkg::ST_ADDR: begin
          if (scl_rise) begin
            shift_nxt = shift_in;
            cnt_nxt   = cnt_r + 4'h1;
            if (byte_done) begin
              // foreign address: drop out until the next start
              state_nxt = addr_match ? nvc_pkg::ST_AACK : nvc_pkg::ST_IDLE;
              rd_nxt    = shift_in[0];
            end
          end
        end
        nvc_pkg::ST_AACK: begin
          if (scl_fall && !sda_oe) begin
            sda_out_nxt = 1'b0;
            sda_oe_nxt  = 1'b1;
          end else if (scl_fall && sda_oe) begin
            cnt_nxt = 4'h0;
            if (rd_r) begin
              state_nxt   = nvc_pkg::ST_RDAT;
              shift_nxt   = rd_byte;
              sda_out_nxt = rd_byte[7];
              sda_oe_nxt  = ~rd_byte[7];
            end else begin
              state_nxt  = nvc_pkg::ST_WDAT;
              sda_oe_nxt = 1'b0;
            end
          end
        end
        nvc_pkg::ST_WDAT: begin
          if (scl_rise) begin
            shift_nxt = shift_in;
            cnt_nxt   = cnt_r + 4'h1;
            if (byte_done) begin
              word_nxt  = shift_in[`NVC_WORD_BITS-1:0];
              state_nxt = nvc_pkg::ST_DACK;
            end
          end
        end
        nvc_pkg::ST_DACK: begin
          // extra bytes after the single data byte are not acknowledged
          if (scl_fall && !sda_oe && cnt_r == 4'h8) begin
            sda_out_nxt = 1'b0;
            sda_oe_nxt  = 1'b1;
            cnt_nxt     = 4'h9;
          end else if (scl_fall && sda_oe) begin
            sda_oe_nxt = 1'b0;
          end
        end
        nvc_pkg::ST_RDAT: begin
          // open drain: drive only zeros, release for ones
          if (scl_fall && cnt_r < 4'h7) begin
            shift_nxt   = {shift_r[6:0], 1'b0};
            sda_out_nxt = 1'b0;
            sda_oe_nxt  = ~shift_r[6];
            cnt_nxt     = cnt_r + 4'h1;
          end else if (scl_fall) begin
            sda_oe_nxt = 1'b0;
            state_nxt  = nvc_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= nvc_pkg::ST_IDLE;
      shift_r <= 8'h00;
      cnt_r   <= 4'h0;
      rd_r    <= 1'b0;
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      cnt_r   <= cnt_nxt;
      rd_r    <= rd_nxt;
      sda_out <= sda_out_nxt;
      sda_oe  <= sda_oe_nxt;
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      word_r <= `NVC_WORD_RESET;
    end else begin
      word_r <= word_nxt;
    end
  end
  // **************************************
  // output path
  // **************************************
  wire [3:0] stored_ratio_bits = word_r[3:0] & {4{~override}};
  wire       stored_aux_bit    = word_r[`NVC_AUX_BIT] & ~override;
  wire [3:0] ratio_sel         = mux_select ? pass_in : stored_ratio_bits;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      core_ratio_code    <= 4'h0;
      latched_aux_output <= 1'b0;
    end else begin
      core_ratio_code <= ratio_sel;
      if (!mux_select) begin
        latched_aux_output <= stored_aux_bit;
      end
    end
  end
  // **************************************
  // checks
  // **************************************
  aux_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    $past(mux_select) |-> latched_aux_output == $past(latched_aux_output))
    else $error("aux output moved while select high");
  aux_follow_a: assert property (@(posedge sys_clk) disable iff (reset)
    !mux_select |=> latched_aux_output == $past(stored_aux_bit))
    else $error("aux output not following stored bit");
  ratio_mux_a: assert property (@(posedge sys_clk) disable iff (reset)
    1'b1 |=> core_ratio_code == ($past(mux_select) ? $past(pass_in) : $past(stored_ratio_bits)))
    else $error("ratio selector wrong");
  override_clr_a: assert property (@(posedge sys_clk) disable iff (reset)
    (override && !mux_select) |=> core_ratio_code == 4'h0 && !latched_aux_output)
    else $error("override did not clear outputs");
  addr_reject_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state_r == nvc_pkg::ST_ADDR && scl_rise && byte_done && !addr_match && !start_det && !stop_det)
    |=> state_r == nvc_pkg::ST_IDLE)
    else $error("foreign address accepted");
  ack_low_a: assert property (@(posedge sys_clk) disable iff (reset)
    sda_oe |-> !sda_out)
    else $error("driving sda high");
  word_write_a: assert property (@(posedge sys_clk) disable iff (reset)
    (word_r != $past(word_r)) |-> $past(state_r == nvc_pkg::ST_WDAT && scl_rise))
    else $error("word changed outside a write");
  // a zero bit is sent by pulling the line, so the msb shows as sda_oe high
  sequence rd_launch_s;
    state_r == nvc_pkg::ST_AACK && scl_fall && sda_oe && rd_r && !start_det && !stop_det;
  endsequence
  sequence msb_low_s;
    state_r == nvc_pkg::ST_RDAT && sda_oe && !sda_out;
  endsequence
  top_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
    rd_launch_s |=> msb_low_s)
    else $error("read msb not zero");
  top_bits_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state_r == nvc_pkg::ST_RDAT && cnt_r < 4'h3) |-> sda_oe && !sda_out)
    else $error("read top bits not zero");
endmodule

/* verilog/nvc_cfg.svh */
// constants for the nonvolatile ratio configuration block
`ifndef NVC_CFG_SVH
`define NVC_CFG_SVH
`define NVC_SLAVE_ADDR   7'h4E
`define NVC_WORD_BITS    5
`define NVC_AUX_BIT      4
`define NVC_WORD_RESET   5'h00
`define NVC_CLK_HZ       20000000
`define NVC_FAST_HZ      400000
`define NVC_STD_HZ       100000
`endif

/* verilog/nvc_pkg.sv */
// types for the nonvolatile ratio configuration block
package nvc_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_AACK = 6'h04,
    ST_WDAT = 6'h08,
    ST_DACK = 6'h10,
    ST_RDAT = 6'h20
  } nvc_state_e;
endpackage

/* verilog/nvc_sync.sv */
// two-flop synchroniser with glitch filter for the bus pins
module nvc_sync (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic raw_in,
  output logic      clean_r
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  wire  agree = (s2_r == s3_r);
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s1_r    <= 1'b1;
      s2_r    <= 1'b1;
      s3_r    <= 1'b1;
      clean_r <= 1'b1;
    end else begin
      s1_r <= raw_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (agree) begin
        clean_r <= s3_r;
      end
    end
  end
endmodule

/* sim/nvc_master_model.sv */
// i2c bus master model standing in for the management bus chipset
module nvc_master_model (
  input  wire logic sys_clk,
  input  wire logic sda_bus,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********************************
  // bus timing
  // ********************************
  // half period in sys_clk cycles: 25 is 400 kHz, 100 is 100 kHz
  int half = 25;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // ********************************
  // framing and bits
  // ********************************
  // also serves as a repeated start when scl is low
  task automatic start();
    sda_low = 1'b0;
    tick(half);
    scl = 1'b1;
    tick(half);
    sda_low = 1'b1;
    tick(half);
    scl = 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sda_low = 1'b1;
    tick(half);
    scl = 1'b1;
    tick(half);
    sda_low = 1'b0;
    tick(half);
  endtask
  // sda moves two cycles after scl falls so the slave sees a hold time
  task automatic bitx(input logic b, output logic r);
    tick(2);
    sda_low = !b;
    tick(half);
    scl = 1'b1;
    tick(half);
    r = sda_bus;
    scl = 1'b0;
  endtask
  // eight bits msb first, then the ack slot; rel=1 releases sda for it
  task automatic xfer(input logic [7:0] d, input logic rel, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(rel, ack);
  endtask
endmodule

/* sim/nvc_top_bench.sv */
// self-checking bench for the ratio configuration slave
`include "nvc_cfg.svh"
module nvc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk = 1'b0;
  logic       reset;
  logic       scl;
  logic       m_low;
  logic       sda_bus;
  logic       sda_out;
  logic       sda_oe;
  logic       mux_select;
  logic       override;
  logic [3:0] pass_in;
  logic [3:0] core_ratio_code;
  logic       latched_aux_output;
  logic [7:0] q;
  logic       a;
  int         n_fail = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  // pull-up when nobody drives; the slave's data bit counts only while enabled
  assign sda_bus = m_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);
  nvc_top u_nvc_top (.sys_clk(sys_clk), .reset(reset), .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out),
    .sda_oe(sda_oe), .mux_select(mux_select), .override(override), .pass_in(pass_in),
    .core_ratio_code(core_ratio_code), .latched_aux_output(latched_aux_output));
  nvc_master_model u_nvc_master_model (.sys_clk(sys_clk), .sda_bus(sda_bus), .scl(scl), .sda_low(m_low));
  initial begin
    forever #25 sys_clk = !sys_clk;
  end
  // ********************************
  // checking and closing
  // ********************************
  // whole run is near 20000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      results();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic outs(input logic [7:0] exp);
    chk({3'h0, latched_aux_output, core_ratio_code}, exp);
  endtask
  // ********************************
  // bus transactions
  // ********************************
  // a refused address gets no data byte
  task automatic wr(input logic [6:0] adr, input logic [7:0] d, input logic nack);
    u_nvc_master_model.start();
    u_nvc_master_model.xfer({adr, 1'b0}, 1'b1, q, a);
    chk({7'h0, a}, {7'h0, nack});
    if (!nack) u_nvc_master_model.xfer(d, 1'b1, q, a);
    if (!nack) chk({7'h0, a}, 8'h00);
    u_nvc_master_model.stop();
    step(3);
  endtask
  task automatic rd(input logic [7:0] exp);
    u_nvc_master_model.start();
    u_nvc_master_model.xfer({7'(`NVC_SLAVE_ADDR), 1'b1}, 1'b1, q, a);
    chk({7'h0, a}, 8'h00);
    u_nvc_master_model.xfer(8'hFF, 1'b1, q, a);
    u_nvc_master_model.stop();
    chk(q, exp);
  endtask
  // ********************************
  // tests
  // ********************************
  initial begin
    reset = 1'b1;
    mux_select = 1'b0;
    override = 1'b0;
    pass_in = 4'h0;
    repeat (2) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    step(5);
    outs(8'h00);
    rd(8'h00);
    $display("test reset done");
    wr(7'h4E, 8'h1A, 1'b0);
    outs(8'h1A);
    rd(8'h1A);
    wr(7'h4E, 8'hEF, 1'b0);
    rd(8'h0F);
    $display("test write read done");
    foreach (pass_in[i]) wr(7'h4E ^ (7'h01 << i), 8'h11, 1'b1);
    outs(8'h0F);
    $display("test address done");
    wr(7'h4E, 8'h10, 1'b0);
    mux_select = 1'b1;
    pass_in = 4'h5;
    step(2);
    outs(8'h15);
    wr(7'h4E, 8'h03, 1'b0);
    outs(8'h15);
    mux_select = 1'b0;
    step(2);
    outs(8'h03);
    $display("test select done");
    wr(7'h4E, 8'h1F, 1'b0);
    override = 1'b1;
    step(2);
    outs(8'h00);
    mux_select = 1'b1;
    step(2);
    override = 1'b0;
    step(2);
    outs(8'h05);
    mux_select = 1'b0;
    step(2);
    outs(8'h1F);
    $display("test override done");
    u_nvc_master_model.half = 100;
    wr(7'h4E, 8'h15, 1'b0);
    rd(8'h15);
    $display("test standard rate done");
    results();
  end
endmodule
